// File: design/chgtc_core.v
// Notes on behaviour
// - skip voltage phase between current steps when set
// - backup mode blocks discharge until pack 0.6V low
// - prequal threshold is undervolt level plus code*20mV
// - precharge current is room*(1+code)/256, rounded
// - min system level holds discharge FET off
// - codes 1..7: empty+0.2V down 100mV steps
// - FET heat limit is code times 25.5mW
// - FET temp is th2 plus gradient times factor/8
// - no thermistor or power-fail: use chip temperature
// - restrict charging above 75C plus 4C per code
// - record OCV at full, restart on drop
// - voltage target automatic unless host override set
// - current target automatic unless host override set
// - full needs OCV, both currents, timer expired
// - termination current from NV or one third
// - scale bit picks 4.2V/5mV or 3.7V/10mV
// - room voltage is centre plus signed code*step
// - warm, hot1, hot2 subtract offsets cumulatively
// - cool, cold1, cold2 subtract offsets cumulatively
// - protection threshold follows region charge voltage
// - currents scaled by step; zero offsets give flat
// - room current is (code+1) times step
`include "chgtc_defs.vh"
module chgtc_core (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire        reg_wr,
    input  wire [8:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire [15:0] nv_termination_current,
    input  wire        nv_term_backup_en,
    input  wire [15:0] full_capacity_nom,
    input  wire        host_target_override,
    input  wire        volt_scale,
    input  wire [2:0]  current_step_lsb,
    input  wire [2:0]  temp_region,
    input  wire [2:0]  charge_step,
    input  wire        source_overloaded,
    input  wire [15:0] cell_voltage,
    input  wire [15:0] pack_voltage,
    input  wire [15:0] empty_voltage,
    input  wire [15:0] undervolt_protect_level,
    input  wire [15:0] filtered_rest_voltage,
    input  wire [15:0] full_rest_threshold,
    input  wire [15:0] instant_current,
    input  wire [15:0] averaged_current,
    input  wire [15:0] chip_temperature,
    input  wire [15:0] second_thermistor_temp,
    input  wire        second_thermistor_used,
    input  wire        power_fail_pin,
    output reg  [15:0] prequal_threshold,
    output reg  [15:0] precharge_current,
    output reg  [15:0] fet_power_limit_code,
    output reg  [15:0] junction_temp_est,
    output reg         junction_temp_limit,
    output reg         discharge_fet_hold,
    output reg  [15:0] overvolt_base,
    output reg         volt_phase_insert,
    output reg         charge_full,
    output reg  [15:0] rest_voltage_at_full
);
    reg  [15:0] target_charge_current;
    reg  [15:0] target_charge_voltage;
    reg  [15:0] termination_current;
    reg  [15:0] cfg_prequal;
    reg  [15:0] cfg_thermal;
    reg  [15:0] vcfg_a;
    reg  [15:0] vcfg_b;
    reg  [15:0] icfg_a;
    reg  [15:0] icfg_b;
    reg  [1:0]  restart_drop_code;
    reg  [31:0] full_qualify_timer;
    reg  [2:0]  last_region;
    reg  [2:0]  last_step;
    reg         recalc_pending;

    wire        volt_phase_skip         = cfg_prequal[15];
    wire        standby_cell_mode       = cfg_prequal[14];
    wire [3:0]  prequal_threshold_code  = cfg_prequal[12:9];
    wire [2:0]  min_system_level        = cfg_prequal[8:6];
    wire [5:0]  precharge_level_code    = cfg_prequal[5:0];
    wire [6:0]  fet_power_limit         = cfg_thermal[15:9];
    wire [3:0]  junction_temp_ceiling   = cfg_thermal[8:5];
    wire [4:0]  junction_gradient_factor = cfg_thermal[4:0];
    wire [7:0]  nominal_region_volt_code = vcfg_a[11:4];
    wire [7:0]  nominal_region_current_code = icfg_a[11:4];

    // region voltage/current codes, offsets applied cumulatively
    reg  signed [11:0] vcode;
    reg  signed [11:0] icode;
    reg  signed [19:0] vsum;
    reg  signed [19:0] isum;
    reg  [15:0] next_vtarget;
    reg  [15:0] next_itarget;
    always @* begin
        vcode = {{4{nominal_region_volt_code[7]}}, nominal_region_volt_code};
        icode = {4'h0, nominal_region_current_code} + 12'sd1;
        case (temp_region)
            `CHGTC_RG_WARM: begin
                vcode = vcode - $signed({8'h0, vcfg_a[15:12]});
                icode = icode - $signed({8'h0, icfg_a[15:12]});
            end
            `CHGTC_RG_HOT1: begin
                vcode = vcode - $signed({8'h0, vcfg_a[15:12]}) - $signed({8'h0, vcfg_b[11:8]});
                icode = icode - $signed({8'h0, icfg_a[15:12]}) - $signed({8'h0, icfg_b[11:8]});
            end
            `CHGTC_RG_HOT2: begin
                vcode = vcode - $signed({8'h0, vcfg_a[15:12]}) - $signed({8'h0, vcfg_b[11:8]})
                        - $signed({8'h0, vcfg_b[15:12]});
                icode = icode - $signed({8'h0, icfg_a[15:12]}) - $signed({8'h0, icfg_b[11:8]})
                        - $signed({8'h0, icfg_b[15:12]});
            end
            `CHGTC_RG_COOL: begin
                vcode = vcode - $signed({8'h0, vcfg_a[3:0]});
                icode = icode - $signed({8'h0, icfg_a[3:0]});
            end
            `CHGTC_RG_COLD1: begin
                vcode = vcode - $signed({8'h0, vcfg_a[3:0]}) - $signed({8'h0, vcfg_b[7:4]});
                icode = icode - $signed({8'h0, icfg_a[3:0]}) - $signed({8'h0, icfg_b[7:4]});
            end
            `CHGTC_RG_COLD2: begin
                vcode = vcode - $signed({8'h0, vcfg_a[3:0]}) - $signed({8'h0, vcfg_b[7:4]})
                        - $signed({8'h0, vcfg_b[3:0]});
                icode = icode - $signed({8'h0, icfg_a[3:0]}) - $signed({8'h0, icfg_b[7:4]})
                        - $signed({8'h0, icfg_b[3:0]});
            end
            default: begin
                vcode = vcode;
                icode = icode;
            end
        endcase
        // a negative current code clamps to zero rather than wrapping
        if (icode < 12'sd0)
            icode = 12'sd0;
        vsum = (volt_scale ? $signed({4'h0, `CHGTC_CV_3V7}) : $signed({4'h0, `CHGTC_CV_4V2}))
               + ($signed({{8{vcode[11]}}, vcode}) <<< (volt_scale ? `CHGTC_VSTEP_SH_1
               : `CHGTC_VSTEP_SH_0));
        next_vtarget = vsum[15:0];
        isum = $signed({8'h0, icode[11:0]}) * $signed({17'h0, current_step_lsb});
        next_itarget = isum[15:0];
    end

    // precharge: room*(1+code)/256, rounded to the current step
    reg  [23:0] pre_raw;
    reg  [15:0] pre_units;
    reg  [15:0] room_cur;
    always @* begin
        room_cur  = {8'h00, nominal_region_current_code} + 16'h0001;
        pre_raw   = room_cur * ({10'h000, precharge_level_code} + 16'h0001);
        pre_units = pre_raw[23:8] + {15'h0000, pre_raw[7]};
        if (pre_units == 16'h0000)
            pre_units = 16'h0001;
    end

    // junction estimate: th2 + (th2-die)*factor/8
    reg  signed [22:0] grad;
    reg  signed [16:0] tdiff;
    reg  [15:0] next_jtemp;
    always @* begin
        tdiff = $signed({second_thermistor_temp[15], second_thermistor_temp})
                - $signed({chip_temperature[15], chip_temperature});
        grad  = ($signed({{6{tdiff[16]}}, tdiff}) * $signed({18'h0, junction_gradient_factor})) >>> 3;
        if (power_fail_pin || !second_thermistor_used)
            next_jtemp = chip_temperature;
        else
            next_jtemp = second_thermistor_temp + grad[15:0];
    end

    reg  [15:0] min_sys_volt;
    always @* begin
        case (min_system_level)
            3'h1: min_sys_volt = empty_voltage + `CHGTC_MV200;
            3'h2: min_sys_volt = empty_voltage + `CHGTC_MV100;
            3'h3: min_sys_volt = empty_voltage;
            3'h4: min_sys_volt = empty_voltage - `CHGTC_MV100;
            3'h5: min_sys_volt = empty_voltage - `CHGTC_MV200;
            3'h6: min_sys_volt = empty_voltage - `CHGTC_MV200 - `CHGTC_MV100;
            3'h7: min_sys_volt = empty_voltage - `CHGTC_MV200 - `CHGTC_MV200;
            default: min_sys_volt = 16'h0000;
        endcase
    end

    wire current_low = $signed(instant_current) < $signed(termination_current)
                       && $signed(averaged_current) < $signed(termination_current);
    wire ocv_high    = filtered_rest_voltage > full_rest_threshold;
    wire timer_done  = full_qualify_timer >= `CHGTC_FULL_CYCLES;
    wire [15:0] restart_level = rest_voltage_at_full
                                - ({14'h0000, restart_drop_code} + 16'h0001) * `CHGTC_MV10;
    wire [17:0] third_cap = {2'b00, full_capacity_nom} * 18'h00001;
    wire region_change = (temp_region != last_region) || (charge_step != last_step);
    wire host_write_v  = reg_wr && reg_addr == `CHGTC_ADDR_VCHG && host_target_override;
    wire host_write_i  = reg_wr && reg_addr == `CHGTC_ADDR_ICHG && host_target_override;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            target_charge_current <= 16'h0000;
            target_charge_voltage <= 16'h0000;
            termination_current   <= 16'h0000;
            cfg_prequal           <= 16'h0000;
            cfg_thermal           <= 16'h0000;
            vcfg_a                <= 16'h0000;
            vcfg_b                <= 16'h0000;
            icfg_a                <= 16'h0000;
            icfg_b                <= 16'h0000;
            restart_drop_code     <= `CHGTC_CFG2_CODE_RST;
            full_qualify_timer    <= 32'h0000_0000;
            last_region           <= 3'h0;
            last_step             <= 3'h0;
            recalc_pending        <= 1'b1;
            charge_full           <= 1'b0;
            rest_voltage_at_full  <= 16'h0000;
        end else begin
            // reload after reset: NV copy or a third of nominal capacity
            if (recalc_pending) begin
                termination_current <= nv_term_backup_en ? nv_termination_current
                                       : third_cap[15:0] / 16'h0003;
            end
            last_region    <= temp_region;
            last_step      <= charge_step;
            recalc_pending <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `CHGTC_ADDR_TERM:  termination_current <= reg_wdata;
                    `CHGTC_ADDR_CFG0:  cfg_prequal <= {reg_wdata[15:14], 1'b0, reg_wdata[12:0]};
                    `CHGTC_ADDR_CFG1:  cfg_thermal <= reg_wdata;
                    `CHGTC_ADDR_VCFGA: vcfg_a <= reg_wdata;
                    `CHGTC_ADDR_VCFGB: vcfg_b <= reg_wdata;
                    `CHGTC_ADDR_ICFGA: icfg_a <= reg_wdata;
                    `CHGTC_ADDR_ICFGB: icfg_b <= reg_wdata;
                    `CHGTC_ADDR_CFG2:  restart_drop_code <= reg_wdata[15:14];
                    default: ;
                endcase
            end
            // host owns the targets while override is set; otherwise recompute
            if (host_write_v)
                target_charge_voltage <= reg_wdata;
            else if (!host_target_override)
                target_charge_voltage <= next_vtarget;
            if (host_write_i)
                target_charge_current <= reg_wdata;
            else if (!host_target_override)
                target_charge_current <= next_itarget;
            // full qualification timer runs while the other conditions hold
            if (ocv_high && current_low && !charge_full) begin
                if (!timer_done)
                    full_qualify_timer <= full_qualify_timer + 32'h0000_0001;
            end else begin
                full_qualify_timer <= 32'h0000_0000;
            end
            if (!charge_full && ocv_high && current_low && timer_done) begin
                charge_full          <= 1'b1;
                rest_voltage_at_full <= filtered_rest_voltage;
            end else if (charge_full && filtered_rest_voltage < restart_level) begin
                charge_full <= 1'b0;
            end
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prequal_threshold    <= 16'h0000;
            precharge_current    <= 16'h0000;
            fet_power_limit_code <= 16'h0000;
            junction_temp_est    <= 16'h0000;
            junction_temp_limit  <= 1'b0;
            discharge_fet_hold   <= 1'b0;
            overvolt_base        <= 16'h0000;
            volt_phase_insert    <= 1'b1;
        end else begin
            prequal_threshold    <= undervolt_protect_level
                                    + {12'h000, prequal_threshold_code} * `CHGTC_MV20;
            precharge_current    <= pre_units * {13'h0000, current_step_lsb};
            fet_power_limit_code <= {9'h000, fet_power_limit};
            junction_temp_est    <= next_jtemp;
            // ceilings above 127C do not fit the signed format, so compare one bit wider
            junction_temp_limit  <= $signed({next_jtemp[15], next_jtemp}) >= $signed({1'b0, `CHGTC_JUNCTION_TEMP_CEILING_BASE
                                    + {12'h000, junction_temp_ceiling} * `CHGTC_JUNCTION_TEMP_CEILING_STEP});
            // discharge blocked in backup mode or while system is held up
            discharge_fet_hold   <= (standby_cell_mode
                                     && {1'b0, pack_voltage} + {1'b0, `CHGTC_MV600} > {1'b0, cell_voltage})
                                    || (source_overloaded && min_system_level != 3'h0
                                        && cell_voltage < min_sys_volt);
            overvolt_base        <= next_vtarget;
            volt_phase_insert    <= !volt_phase_skip;
        end
    end

    always @* begin
        case (reg_addr)
            `CHGTC_ADDR_ICHG:  reg_rdata = target_charge_current;
            `CHGTC_ADDR_VCHG:  reg_rdata = target_charge_voltage;
            `CHGTC_ADDR_TERM:  reg_rdata = termination_current;
            `CHGTC_ADDR_CFG0:  reg_rdata = cfg_prequal;
            `CHGTC_ADDR_CFG1:  reg_rdata = cfg_thermal;
            `CHGTC_ADDR_VCFGA: reg_rdata = vcfg_a;
            `CHGTC_ADDR_VCFGB: reg_rdata = vcfg_b;
            `CHGTC_ADDR_ICFGA: reg_rdata = icfg_a;
            `CHGTC_ADDR_ICFGB: reg_rdata = icfg_b;
            `CHGTC_ADDR_CFG2:  reg_rdata = {restart_drop_code, `CHGTC_CFG2_FIXED};
            default:           reg_rdata = 16'h0000;
        endcase
    end
endmodule

// File: design/chgtc_defs.vh
`ifndef CHGTC_DEFS_VH
`define CHGTC_DEFS_VH
// register addresses (9-bit internal space)
`define CHGTC_ADDR_ICHG      9'h028
`define CHGTC_ADDR_VCHG      9'h02A
`define CHGTC_ADDR_TERM      9'h1C1
`define CHGTC_ADDR_CFG0      9'h1C2
`define CHGTC_ADDR_CFG1      9'h1CB
`define CHGTC_ADDR_VCFGA     9'h1CC
`define CHGTC_ADDR_VCFGB     9'h1CD
`define CHGTC_ADDR_ICFGA     9'h1CE
`define CHGTC_ADDR_ICFGB     9'h1CF
`define CHGTC_ADDR_CFG2      9'h1E4
// reset values
`define CHGTC_CFG2_RESET     16'h1800
`define CHGTC_CFG2_FIXED     14'h1800
`define CHGTC_CFG2_CODE_RST  2'h0
// voltage register lsb is 78.125uV: 5mV = 64 lsb, 10mV = 128 lsb
`define CHGTC_CV_4V2         16'hD200
`define CHGTC_CV_3V7         16'hB900
`define CHGTC_VSTEP_SH_0     4'h6
`define CHGTC_VSTEP_SH_1     4'h7
`define CHGTC_MV20           16'h0100
`define CHGTC_MV10           16'h0080
`define CHGTC_MV100          16'h0500
`define CHGTC_MV200          16'h0A00
`define CHGTC_MV600          16'h1E00
// temperature lsb is 1/256 degC
`define CHGTC_JUNCTION_TEMP_CEILING_BASE    16'h4B00
`define CHGTC_JUNCTION_TEMP_CEILING_STEP    16'h0400
// full timer, in core_clk cycles
`define CHGTC_FULL_CYCLES    32'h0000_1000
// temperature regions
`define CHGTC_RG_ROOM        3'h0
`define CHGTC_RG_WARM        3'h1
`define CHGTC_RG_HOT1        3'h2
`define CHGTC_RG_HOT2        3'h3
`define CHGTC_RG_COOL        3'h4
`define CHGTC_RG_COLD1       3'h5
`define CHGTC_RG_COLD2       3'h6
// charge phases
`define CHGTC_PH_PREQ        2'h0
`define CHGTC_PH_CC          2'h1
`define CHGTC_PH_CV          2'h2
`define CHGTC_PH_FULL        2'h3
`endif

// File: bench/chgtc_core_checker.sv
`include "chgtc_defs.vh"
module chgtc_core_checker (
    input logic        core_clk,
    input logic        resetn,
    input logic        reg_wr,
    input logic [8:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        host_target_override,
    input logic [15:0] undervolt_protect_level,
    input logic [15:0] filtered_rest_voltage,
    input logic [15:0] full_rest_threshold,
    input logic [15:0] chip_temperature,
    input logic        second_thermistor_used,
    input logic        power_fail_pin,
    input logic [15:0] prequal_threshold,
    input logic [15:0] fet_power_limit_code,
    input logic [15:0] junction_temp_est,
    input logic        volt_phase_insert,
    input logic        charge_full,
    input logic [15:0] rest_voltage_at_full
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  up;
    logic [15:0] cfg0_sh;
    logic [6:0]  heat_sh;
    logic [1:0]  rcode_sh;
    logic [12:0] ocv_run;
    // $past is only trusted once two edges have passed since reset
    wire         ok = (up == 2'h2);
    wire  [3:0]  pq_code = cfg0_sh[12:9];
    wire         skip_bit = cfg0_sh[15];
    wire  [15:0] rdrop = {6'h0, {1'b0, rcode_sh} + 3'h1, 7'h0};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            up <= 2'h0;
            cfg0_sh <= 16'h0;
            heat_sh <= 7'h0;
            rcode_sh <= 2'h0;
            ocv_run <= 13'h0;
        end else begin
            if (up != 2'h2)
                up <= up + 2'h1;
            if (reg_wr && reg_addr == `CHGTC_ADDR_CFG0)
                cfg0_sh <= reg_wdata;
            if (reg_wr && reg_addr == `CHGTC_ADDR_CFG1)
                heat_sh <= reg_wdata[15:9];
            if (reg_wr && reg_addr == `CHGTC_ADDR_CFG2)
                rcode_sh <= reg_wdata[15:14];
            if (filtered_rest_voltage <= full_rest_threshold)
                ocv_run <= 13'h0;
            else if (ocv_run != 13'h1FFF)
                ocv_run <= ocv_run + 13'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_prequal_sum: assert property (ok |-> prequal_threshold ==
        $past(undervolt_protect_level) + {4'h0, $past(pq_code), 8'h00}) else $error("prequal threshold wrong");
    a_phase_skip: assert property (ok |-> volt_phase_insert == !$past(skip_bit))
        else $error("phase insert wrong");
    a_heat_code: assert property (ok |-> fet_power_limit_code == {9'h0, $past(heat_sh)})
        else $error("heat limit code wrong");
    a_die_fallback: assert property (ok && ($past(power_fail_pin) || !$past(second_thermistor_used))
        |-> junction_temp_est == $past(chip_temperature)) else $error("fet estimate not die temp");
    a_host_target: assert property (reg_wr && host_target_override && reg_addr == `CHGTC_ADDR_VCHG
        |=> reg_addr != `CHGTC_ADDR_VCHG || reg_rdata == $past(reg_wdata)) else $error("host target lost");
    a_full_ocv: assert property ($rose(charge_full) |->
        $past(filtered_rest_voltage) > $past(full_rest_threshold)) else $error("full without ocv");
    a_full_timer: assert property ($rose(charge_full) |-> ocv_run >= 13'h1000)
        else $error("full before timer");
    a_restart_drop: assert property ($fell(charge_full) |->
        $past(filtered_rest_voltage) < $past(rest_voltage_at_full) - $past(rdrop)) else $error("early restart");
    a_unmapped_zero: assert property (reg_addr == 9'h1FF |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    cover property ($rose(charge_full));
    cover property ($fell(charge_full));
    cover property (ok && power_fail_pin);
endmodule

// File: bench/chgtc_core_tb_top.sv
`include "chgtc_defs.vh"
module chgtc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, resetn, reg_wr, nv_term_backup_en, host_target_override, volt_scale;
    logic        source_overloaded, second_thermistor_used, power_fail_pin;
    logic [8:0]  reg_addr;
    logic [2:0]  current_step_lsb, temp_region, charge_step;
    logic [15:0] reg_wdata, nv_termination_current, full_capacity_nom, cell_voltage, pack_voltage;
    logic [15:0] empty_voltage, undervolt_protect_level, filtered_rest_voltage, full_rest_threshold;
    logic [15:0] instant_current, averaged_current, chip_temperature, second_thermistor_temp;
    wire  [15:0] reg_rdata, prequal_threshold, precharge_current, fet_power_limit_code;
    wire  [15:0] junction_temp_est, overvolt_base, rest_voltage_at_full;
    wire         junction_temp_limit, discharge_fet_hold, volt_phase_insert, charge_full;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [15:0] va, vb, ia, ib;

    chgtc_core dut_u (.*);

    always #5 core_clk = ~core_clk;

    function automatic int offs(input logic [15:0] a, input logic [15:0] b, input int r);
        case (r)
            1: return a[15:12];
            2: return a[15:12] + b[11:8];
            3: return a[15:12] + b[11:8] + b[15:12];
            4: return a[3:0];
            5: return a[3:0] + b[7:4];
            6: return a[3:0] + b[7:4] + b[3:0];
            default: return 0;
        endcase
    endfunction

    function automatic logic [15:0] vexp(input int r);
        int c;
        c = $signed(va[11:4]) - offs(va, vb, r);
        return (volt_scale ? `CHGTC_CV_3V7 : `CHGTC_CV_4V2) + c * (volt_scale ? 128 : 64);
    endfunction

    function automatic logic [15:0] iexp(input int r);
        int c;
        c = ia[11:4] + 1 - offs(ia, ib, r);
        if (c < 0)
            c = 0;
        return c * current_step_lsb;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] e, input string w);
        @(negedge core_clk);
        reg_addr = a;
        #1 chk(w, e, reg_rdata);
    endtask

    task automatic do_reset;
        resetn = 1'b0;
        tk(10);
        resetn = 1'b1;
        tk(1);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // full-timer waits dominate the run; the span is over twice their length
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        int i, j, k, r;
        core_clk = 1'b0;
        resetn = 1'b0;
        {reg_wr, nv_term_backup_en, host_target_override, volt_scale, source_overloaded, power_fail_pin} = '0;
        {reg_addr, temp_region, charge_step, reg_wdata, nv_termination_current, instant_current} = '0;
        second_thermistor_used = 1'b1;
        current_step_lsb = 3'h5;
        full_capacity_nom = 16'h0300;
        {cell_voltage, pack_voltage, empty_voltage, averaged_current} = {16'hA000, 16'hA000, 16'hA000, 16'h0400};
        undervolt_protect_level = 16'h9000;
        {filtered_rest_voltage, full_rest_threshold} = {16'hB000, 16'hC000};
        {chip_temperature, second_thermistor_temp} = {16'h1400, 16'h1E00};
        do_reset();
        rd(`CHGTC_ADDR_TERM, 16'h0100, "term_fallback");
        rd(`CHGTC_ADDR_CFG2, `CHGTC_CFG2_RESET, "cfg2_reset");
        rd(`CHGTC_ADDR_CFG0, 16'h0000, "cfg0_reset");
        rd(9'h1FF, 16'h0000, "unmapped");
        wr(`CHGTC_ADDR_CFG0, 16'hFFFF);
        rd(`CHGTC_ADDR_CFG0, 16'hDFFF, "cfg0_fixed");
        wr(`CHGTC_ADDR_CFG2, 16'hFFFF);
        rd(`CHGTC_ADDR_CFG2, 16'hD800, "cfg2_fixed");
        $display("test registers done");
        wr(`CHGTC_ADDR_ICFGA, 16'h03F0);
        for (i = 0; i < 3; i++) begin
            wr(`CHGTC_ADDR_CFG0, {i[0], 2'h0, 4'hF, 3'h0, (i == 0 ? 6'h03 : i == 1 ? 6'h3F : 6'h00)});
            tk(2);
            chk("precharge", 16'(current_step_lsb * (i == 1 ? 16 : 1)), precharge_current);
            chk("phase_insert", !i[0], volt_phase_insert);
            chk("prequal", undervolt_protect_level + 16'h0F00, prequal_threshold);
        end
        $display("test prequal done");
        source_overloaded = 1'b1;
        for (i = 0; i < 8; i++) begin
            wr(`CHGTC_ADDR_CFG0, 16'(i << 6));
            for (j = 0; j < 2; j++) begin
                cell_voltage = 16'(empty_voltage + 'h0A00 - (i - 1) * 'h0500 + (j ? 'h10 : -'h10));
                tk(2);
                chk("sys_hold", i != 0 && j == 0, discharge_fet_hold);
            end
        end
        source_overloaded = 1'b0;
        wr(`CHGTC_ADDR_CFG0, 16'h4000);
        for (j = 0; j < 2; j++) begin
            pack_voltage = 16'(cell_voltage - 'h1E00 + (j ? -'h10 : 'h10));
            tk(2);
            chk("backup_hold", j == 0, discharge_fet_hold);
        end
        $display("test discharge hold done");
        wr(`CHGTC_ADDR_CFG1, 16'hFE4C);
        tk(2);
        chk("heat", 16'h007F, fet_power_limit_code);
        chk("fet_est", 16'h2D00, junction_temp_est);
        chk("fet_lim", 0, junction_temp_limit);
        chip_temperature = 16'h5400;
        power_fail_pin = 1'b1;
        tk(2);
        chk("fet_die", 16'h5400, junction_temp_est);
        chk("fet_lim", 1, junction_temp_limit);
        {power_fail_pin, second_thermistor_used, chip_temperature} = {2'b00, 16'h5200};
        tk(2);
        chk("fet_die", 16'h5200, junction_temp_est);
        chk("fet_lim", 0, junction_temp_limit);
        wr(`CHGTC_ADDR_CFG1, 16'h01E0);
        tk(2);
        chk("fet_lim_top", 0, junction_temp_limit);
        second_thermistor_used = 1'b1;
        $display("test thermal done");
        for (k = 0; k < 4; k++) begin
            {va, vb, ia, ib} = k[1] ? {16'h0050, 16'h0, 16'h0200, 16'h0} : {16'h2FD1, 16'h1324, 16'h1202, 16'h2113};
            volt_scale = k[0];
            wr(`CHGTC_ADDR_VCFGA, va);
            wr(`CHGTC_ADDR_VCFGB, vb);
            wr(`CHGTC_ADDR_ICFGA, ia);
            wr(`CHGTC_ADDR_ICFGB, ib);
            for (r = 0; r < 7; r++) begin
                {temp_region, charge_step} = {3'(r), 3'(r)};
                tk(2);
                rd(`CHGTC_ADDR_VCHG, vexp(r), "volt_target");
                chk("ov_base", vexp(r), overvolt_base);
                rd(`CHGTC_ADDR_ICHG, iexp(r), "curr_target");
            end
        end
        wr(`CHGTC_ADDR_VCHG, 16'h1234);
        rd(`CHGTC_ADDR_VCHG, vexp(6), "volt_ignored");
        host_target_override = 1'b1;
        wr(`CHGTC_ADDR_VCHG, 16'h1234);
        wr(`CHGTC_ADDR_ICHG, 16'h0456);
        temp_region = 3'h0;
        tk(2);
        rd(`CHGTC_ADDR_VCHG, 16'h1234, "volt_host");
        rd(`CHGTC_ADDR_ICHG, 16'h0456, "curr_host");
        host_target_override = 1'b0;
        tk(2);
        rd(`CHGTC_ADDR_ICHG, iexp(0), "curr_auto");
        $display("test targets done");
        {filtered_rest_voltage, full_rest_threshold, instant_current} = {16'hD000, 16'hC000, 16'h0010};
        tk(4200);
        chk("full_avg_high", 0, charge_full);
        averaged_current = 16'h0010;
        tk(4090);
        chk("full_early", 0, charge_full);
        for (i = 0; i < 20 && charge_full !== 1'b1; i++)
            @(negedge core_clk);
        chk("full_set", 1, charge_full);
        chk("full_ocv", 16'hD000, rest_voltage_at_full);
        {instant_current, filtered_rest_voltage} = {16'h0400, 16'hCE10};
        tk(3);
        chk("full_held", 1, charge_full);
        filtered_rest_voltage = 16'hCDF0;
        tk(3);
        chk("full_clear", 0, charge_full);
        $display("test full done");
        {nv_term_backup_en, nv_termination_current} = {1'b1, 16'h0123};
        do_reset();
        rd(`CHGTC_ADDR_TERM, 16'h0123, "term_nv");
        rd(`CHGTC_ADDR_CFG1, 16'h0000, "cfg1_reset");
        $display("test second reset done");
        summarize();
    end
endmodule

bind chgtc_core chgtc_core_checker chk_u (.*);
